// ==== shared/rate_params.svh ====
// constants of the rate divider and result format
`ifndef RATE_PARAMS_SVH
`define RATE_PARAMS_SVH

// rate control register fields
`define RATE_CTRL_WIDTH 16
`define RATE_COARSE_MSB 15
`define RATE_COARSE_LSB 13
`define RATE_IGNORED_MSB 12
`define RATE_IGNORED_LSB 11
`define RATE_FINE_MSB 10
`define RATE_FINE_LSB 0
`define RATE_IGNORED_MASK 16'he7ff
`define RATE_CTRL_RESET 16'h0000

// divider arithmetic
`define DIV_WIDTH 17
`define DIV_BASE_CYCLES 9'h180
`define FINE_LIMIT 11'h5ff
`define FINE_FRACTION_SHIFT 2
`define DIV_RESET 17'h00600

// result word layout
`define CHAN_WIDTH 24
`define RESULT_WIDTH 96
`define CHAN0_MSB 95
`define CHAN0_LSB 72
`define CHAN1_MSB 71
`define CHAN1_LSB 48
`define CHAN2_MSB 47
`define CHAN2_LSB 24
`define CHAN3_MSB 23
`define CHAN3_LSB 0
`define SHORT_WIDTH 19
`define DEVICE_TAG_WIDTH 3

// result buffering
`define FIFO_DEPTH 16

`endif

// ==== shared/rate_pkg.sv ====
// types and decoders of the rate divider and result format
package rate_pkg;
    typedef logic [23:0] chan_result_type;
    typedef logic [95:0] result_word_type;
    typedef logic [16:0] divider_type;

    typedef enum logic [1:0] {
        OUT_EMPTY = 2'b00,
        OUT_FULL = 2'b01
    } out_state_type;

    // coarse cycle factor per coarse code
    function automatic logic [7:0] coarseFactor(input logic [2:0] code);
        case (code)
            3'h0: coarseFactor = 8'h04;
            3'h1: coarseFactor = 8'h80;
            3'h2: coarseFactor = 8'h40;
            3'h3: coarseFactor = 8'h20;
            3'h4: coarseFactor = 8'h10;
            3'h5: coarseFactor = 8'h08;
            3'h6: coarseFactor = 8'h02;
            default: coarseFactor = 8'h01;
        endcase
    endfunction

    // fine cycle factor in quarter cycles per coarse code
    function automatic logic [7:0] fineQuarters(input logic [2:0] code);
        case (code)
            3'h0: fineQuarters = 8'h04;
            3'h1: fineQuarters = 8'h80;
            3'h2: fineQuarters = 8'h40;
            3'h3: fineQuarters = 8'h20;
            3'h4: fineQuarters = 8'h10;
            3'h5: fineQuarters = 8'h08;
            3'h6: fineQuarters = 8'h02;
            default: fineQuarters = 8'h01;
        endcase
    endfunction
endpackage

// ==== shared/stream_if.sv ====
// valid/ready word stream between the block's own modules
`timescale 1ns/1ps
interface stream_if #(parameter int WIDTH = 96);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface

// ==== src/result_fifo.sv ====
// result word fifo with valid/ready on both sides
`timescale 1ns/1ps
module result_fifo #(
    parameter int WIDTH = 96,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // streams
    stream_if.sink fillSide,
    stream_if.source drainSide
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wrPtr_reg, wrPtr_next;
    logic [PW-1:0] rdPtr_reg, rdPtr_next;
    logic [PW:0] level_reg, level_next;
    logic push, pop;

    assign fillSide.ready = (level_reg != (PW+1)'(DEPTH));
    assign drainSide.valid = (level_reg != '0);
    assign drainSide.data = mem[rdPtr_reg];

    always_comb begin
        push = fillSide.valid && fillSide.ready;
        pop = drainSide.valid && drainSide.ready;
        wrPtr_next = push ? wrPtr_reg + 1'b1 : wrPtr_reg;
        rdPtr_next = pop ? rdPtr_reg + 1'b1 : rdPtr_reg;
        level_next = level_reg;
        if (push && !pop) begin
            level_next = level_reg + 1'b1;
        end else if (pop && !push) begin
            level_next = level_reg - 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            level_reg <= '0;
        end else begin
            wrPtr_reg <= wrPtr_next;
            rdPtr_reg <= rdPtr_next;
            level_reg <= level_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wrPtr_reg] <= fillSide.data;
        end
    end
endmodule

// ==== src/rate_divider.sv ====
// output data period counter driven by the rate control value
`timescale 1ns/1ps
`include "rate_params.svh"
module rate_divider
    import rate_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // setting
    input wire logic [15:0] rateControl,
    // period marker and active divider
    output logic convTick,
    output divider_type activeDivider
);
    logic [2:0] coarse;
    logic [10:0] fine;
    logic [17:0] baseCycles;
    logic [18:0] fineQuarterCycles;
    logic [17:0] sum;
    divider_type newDivider;
    divider_type count_reg, count_next;
    divider_type active_reg, active_next;
    logic tick_reg, tick_next;

    always_comb begin
        coarse = rateControl[`RATE_COARSE_MSB:`RATE_COARSE_LSB];
        fine = rateControl[`RATE_FINE_MSB:`RATE_FINE_LSB];
        // fine values above the limit act as the limit
        if (fine > `FINE_LIMIT) begin
            fine = `FINE_LIMIT;
        end
        baseCycles = 18'(coarseFactor(coarse)) * 18'(`DIV_BASE_CYCLES);
        fineQuarterCycles = 19'(fineQuarters(coarse)) * 19'(fine);
        sum = baseCycles + 18'(fineQuarterCycles >> `FINE_FRACTION_SHIFT);
        newDivider = sum[16:0];
    end

    always_comb begin
        tick_next = 1'b0;
        count_next = count_reg + 1'b1;
        active_next = active_reg;
        if (count_reg >= active_reg - 1'b1) begin
            count_next = '0;
            tick_next = 1'b1;
            active_next = newDivider;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            count_reg <= '0;
            active_reg <= `DIV_RESET;
            tick_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            active_reg <= active_next;
            tick_reg <= tick_next;
        end
    end

    assign convTick = tick_reg;
    assign activeDivider = active_reg;
endmodule

// ==== src/adc_rate_result.sv ====
// rate control, result packing and result buffering of the converter output side
//
// Operation
// - wide mode packs channels 0..3 into bits 95:72, 71:48, 47:24, 23:0
// - wide layout only while wide select set; else 19-bit tagged layout
// - each device contributes one 96-bit result word per read
// - result still held while the fifo is full is overwritten when the next conversion completes
// - output rate is oscillator clock divided by an integer divider
// - divider is coarse factor times 384 plus fine factor times fine value
// - fractional divider results truncate down to an integer
// - rate control writes and reads carry exactly 16 bits
// - new rate value takes effect within one conversion period
// - coarse code in bits 15:13 decodes to factors 4,128,64,32,16,8,2,1
// - fine field in bits 10:0 lengthens period by value times fine factor; values above 0x5ff act as 0x5ff
// - fine factor per coarse code: 1,32,16,8,4,2,1/2,1/4 cycles
`timescale 1ns/1ps
`include "rate_params.svh"
module adc_rate_result
    import rate_pkg::*;
#(
    // device address tag in the short format; value is arbitrary
    parameter logic [2:0] DEVICE_TAG = 3'h0
) (
    // oscillator input clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // rate control register port
    input wire logic rateWrite,
    input wire logic [15:0] rateWriteData,
    output logic [15:0] rateReadData,
    // configuration
    input wire logic wideResultSelect,
    // channel results from the filters
    input wire logic [23:0] chanZeroResult,
    input wire logic [23:0] chanOneResult,
    input wire logic [23:0] chanTwoResult,
    input wire logic [23:0] chanThreeResult,
    // result read port
    input wire logic resultReady,
    output logic resultValid,
    output logic [95:0] resultWord,
    // status
    output logic convDone,
    output logic resultOverwritten
);

    ////////////////////////////////////////////////////////////////////////////
    // packing of one result word

    function automatic result_word_type packWide(
        input chan_result_type c0,
        input chan_result_type c1,
        input chan_result_type c2,
        input chan_result_type c3
    );
        result_word_type w;
        w = '0;
        w[`CHAN0_MSB:`CHAN0_LSB] = c0;
        w[`CHAN1_MSB:`CHAN1_LSB] = c1;
        w[`CHAN2_MSB:`CHAN2_LSB] = c2;
        w[`CHAN3_MSB:`CHAN3_LSB] = c3;
        packWide = w;
    endfunction

    // 19 data bits, device tag, channel tag
    function automatic logic [23:0] shortField(
        input chan_result_type c,
        input logic [1:0] chanTag
    );
        shortField = {c[`CHAN_WIDTH-1:`CHAN_WIDTH-`SHORT_WIDTH], DEVICE_TAG, chanTag};
    endfunction

    function automatic result_word_type packShort(
        input chan_result_type c0,
        input chan_result_type c1,
        input chan_result_type c2,
        input chan_result_type c3
    );
        packShort = {shortField(c0, 2'h0), shortField(c1, 2'h1),
                     shortField(c2, 2'h2), shortField(c3, 2'h3)};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // rate control register

    logic [15:0] rateCtrl_reg, rateCtrl_next;

    always_comb begin
        rateCtrl_next = rateCtrl_reg;
        if (rateWrite) begin
            rateCtrl_next = rateWriteData & `RATE_IGNORED_MASK;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rateCtrl_reg <= `RATE_CTRL_RESET;
        end else begin
            rateCtrl_reg <= rateCtrl_next;
        end
    end

    assign rateReadData = rateCtrl_reg;

    ////////////////////////////////////////////////////////////////////////////
    // conversion period

    logic tick;

    rate_divider divider (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .rateControl(rateCtrl_reg),
        .convTick(tick),
        .activeDivider()
    );

    ////////////////////////////////////////////////////////////////////////////
    // holding register, overwritten when not yet moved on

    stream_if #(.WIDTH(`RESULT_WIDTH)) toFifo ();
    stream_if #(.WIDTH(`RESULT_WIDTH)) fromFifo ();

    result_word_type hold_reg, hold_next;
    logic holdValid_reg, holdValid_next;
    logic overwrite_reg, overwrite_next;
    logic done_reg, done_next;
    result_word_type captured;

    always_comb begin
        if (wideResultSelect) begin
            captured = packWide(chanZeroResult, chanOneResult,
                                chanTwoResult, chanThreeResult);
        end else begin
            captured = packShort(chanZeroResult, chanOneResult,
                                 chanTwoResult, chanThreeResult);
        end
        hold_next = hold_reg;
        holdValid_next = holdValid_reg;
        overwrite_next = 1'b0;
        done_next = tick;
        if (holdValid_reg && toFifo.ready) begin
            holdValid_next = 1'b0;
        end
        // new result wins over the hand-off in the same cycle
        if (tick) begin
            hold_next = captured;
            holdValid_next = 1'b1;
            overwrite_next = holdValid_reg && !toFifo.ready;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            hold_reg <= '0;
            holdValid_reg <= 1'b0;
            overwrite_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            hold_reg <= hold_next;
            holdValid_reg <= holdValid_next;
            overwrite_reg <= overwrite_next;
            done_reg <= done_next;
        end
    end

    assign toFifo.valid = holdValid_reg;
    assign toFifo.data = hold_reg;
    assign convDone = done_reg;
    assign resultOverwritten = overwrite_reg;

    ////////////////////////////////////////////////////////////////////////////
    // buffering

    result_fifo #(
        .WIDTH(`RESULT_WIDTH),
        .DEPTH(`FIFO_DEPTH)
    ) buffer (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .fillSide(toFifo),
        .drainSide(fromFifo)
    );

    ////////////////////////////////////////////////////////////////////////////
    // registered read port

    out_state_type outState_reg, outState_next;
    result_word_type outWord_reg, outWord_next;
    logic take;
    logic valid_reg, valid_next;

    always_comb begin
        outState_next = outState_reg;
        outWord_next = outWord_reg;
        take = 1'b0;
        case (outState_reg)
            OUT_EMPTY: begin
                take = 1'b1;
            end
            OUT_FULL: begin
                take = resultReady;
            end
            default: begin
                take = 1'b0;
            end
        endcase
        if (take) begin
            if (fromFifo.valid) begin
                outState_next = OUT_FULL;
                outWord_next = fromFifo.data;
            end else begin
                outState_next = OUT_EMPTY;
            end
        end
        valid_next = (outState_next == OUT_FULL);
    end

    assign fromFifo.ready = take;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            outState_reg <= OUT_EMPTY;
            outWord_reg <= '0;
            valid_reg <= 1'b0;
        end else begin
            outState_reg <= outState_next;
            outWord_reg <= outWord_next;
            valid_reg <= valid_next;
        end
    end

    assign resultValid = valid_reg;
    assign resultWord = outWord_reg;

endmodule

// ==== bench/adc_rate_result_monitor.sv ====
// concurrent checks on the converter output side ports
`timescale 1ns/1ps
module adc_rate_result_monitor (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // rate control register port
    input wire logic rateWrite,
    input wire logic [15:0] rateWriteData,
    input wire logic [15:0] rateReadData,
    // result read port and status
    input wire logic resultReady,
    input wire logic resultValid,
    input wire logic [95:0] resultWord,
    input wire logic convDone,
    input wire logic resultOverwritten
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    // cycles since the last period marker
    logic [16:0] gap_reg;
    logic [16:0] gap_next;
    always_comb begin
        gap_next = convDone ? 17'h00000 : gap_reg + {16'h0000, gap_reg != 17'h1ffff};
    end
    always_ff @(posedge ref_clk) begin
        gap_reg <= rst_b ? gap_next : 17'h00000;
    end

    ////////////////////////////////////////////////////////////////////////////
    chk_ready_hold: assert property (
        resultValid && !resultReady |=> resultValid && $stable(resultWord))
        else $error("result word changed before the host took it");
    chk_readback_mask: assert property (
        rateWrite |=> rateReadData == ($past(rateWriteData) & 16'he7ff))
        else $error("rate register readback wrong after write");
    chk_read_stable: assert property (
        !rateWrite |=> $stable(rateReadData))
        else $error("rate register changed without a write");
    chk_done_single: assert property (
        convDone |=> !convDone [*8])
        else $error("period marker repeated too soon");
    chk_ovw_near_done: assert property (
        resultOverwritten |-> convDone || $past(convDone))
        else $error("overwrite flagged away from a conversion");
    chk_valid_after_done: assert property (
        convDone && !resultValid |-> ##2 resultValid)
        else $error("new result not offered in time");
    chk_valid_cause: assert property (
        $rose(resultValid) |-> $past(convDone, 2))
        else $error("result offered without a conversion");
    chk_done_spacing: assert property (
        convDone |-> gap_reg >= 17'h0017f && gap_reg <= 17'h17fdf)
        else $error("output data period out of range");
endmodule

bind adc_rate_result adc_rate_result_monitor i_monitor (
    .ref_clk(ref_clk), .rst_b(rst_b), .rateWrite(rateWrite),
    .rateWriteData(rateWriteData), .rateReadData(rateReadData),
    .resultReady(resultReady), .resultValid(resultValid), .resultWord(resultWord),
    .convDone(convDone), .resultOverwritten(resultOverwritten));

// ==== bench/result_host.sv ====
// host model reading result words prompt, slow or stalled
`timescale 1ns/1ps
module result_host (
    // clock
    input wire logic ref_clk,
    // behaviour: 0 prompt, 1 random, 2 stalled
    input wire logic [1:0] mode,
    // result read port
    input wire logic resultValid,
    input wire logic [95:0] resultWord,
    output logic resultReady,
    // word taken at the last edge
    output logic took,
    output logic [95:0] tookWord
);
    initial begin
        resultReady = 1'b0;
        took = 1'b0;
        tookWord = 96'h0;
    end
    always @(negedge ref_clk) begin
        resultReady <= (mode == 2'h0) || (mode == 2'h1 && $urandom_range(1) == 1);
    end
    // whole 96-bit word taken at the ready edge
    always @(posedge ref_clk) begin
        took <= resultValid && resultReady;
        tookWord <= resultWord;
    end
endmodule

// ==== bench/adc_rate_result_tb.sv ====
// self-checking bench of the converter output side
`timescale 1ns/1ps
module adc_rate_result_tb;
    // device tag, value is arbitrary
    localparam logic [2:0] TAG = 3'h5;
    logic ref_clk, rst_b, rateWrite, wideSel, resultReady, resultValid;
    logic convDone, resultOverwritten, took;
    logic [15:0] rateWriteData, rateReadData;
    logic [23:0] chan [4];
    logic [95:0] resultWord, tookWord, w;
    logic [1:0] mode;
    logic [95:0] q [$];
    logic [15:0] sched [8] = '{16'hfffd, 16'hc803, 16'h0000, 16'ha001,
        16'h8000, 16'h6001, 16'h2001, 16'he000};
    int fails = 0, cmpCount = 0, ovExp = 0, ovSeen = 0, i;
    int sinceDone = 0, activeExp = 0, pendingExp = 0;

    adc_rate_result #(.DEVICE_TAG(TAG)) i_dut (.ref_clk(ref_clk), .rst_b(rst_b),
        .rateWrite(rateWrite), .rateWriteData(rateWriteData), .rateReadData(rateReadData),
        .wideResultSelect(wideSel), .chanZeroResult(chan[0]), .chanOneResult(chan[1]),
        .chanTwoResult(chan[2]), .chanThreeResult(chan[3]), .resultReady(resultReady),
        .resultValid(resultValid), .resultWord(resultWord), .convDone(convDone),
        .resultOverwritten(resultOverwritten));
    result_host i_host (.ref_clk(ref_clk), .mode(mode), .resultValid(resultValid),
        .resultWord(resultWord), .resultReady(resultReady), .took(took),
        .tookWord(tookWord));

    ////////////////////////////////////////////////////////////////////////////
    task check(input bit ok, input string m);
        cmpCount++;
        if (!ok) begin
            $display("mismatch at %0t: %s", $time, m);
            fails++;
        end
    endtask
    task tallyAndFinish;
        if (fails == 0 && cmpCount > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    function automatic int dexp(input logic [15:0] v);
        int cf [8];
        int f;
        cf = '{32'h4, 32'h80, 32'h40, 32'h20, 32'h10, 32'h8, 32'h2, 32'h1};
        f = (v[10:0] > 11'h5ff) ? 32'h5ff : int'(v[10:0]);
        // fine factor in quarter cycles equals the coarse factor
        return cf[v[15:13]] * 32'h180 + (cf[v[15:13]] * f) / 32'h4;
    endfunction
    function automatic logic [95:0] pack(input logic wd, input logic [23:0] c [4]);
        logic [95:0] p;
        for (int k = 0; k < 4; k++) begin
            p[95 - 24 * k -: 24] = wd ? c[k] : {c[k][23:5], TAG, 2'(k)};
        end
        return p;
    endfunction
    // write at a falling edge, readback one cycle later
    task wr(input logic [15:0] v);
        rateWrite = 1'b1;
        rateWriteData = v;
        pendingExp = dexp(v);
        @(negedge ref_clk);
        check(rateReadData === (v & 16'he7ff), "rate readback");
    endtask
    task waitDone;
        int n;
        n = 0;
        @(negedge ref_clk);
        while (convDone !== 1'b1 && n < 60000) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 60000) check(1'b0, "no conversion tick");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // result model and period measurement
    always @(negedge ref_clk) begin
        if (took === 1'b1) begin
            check(q.size() > 0 && tookWord === q[0], "result word");
            if (q.size() > 0) void'(q.pop_front());
        end
        if (resultOverwritten === 1'b1) ovSeen++;
        if (rst_b === 1'b1 && convDone === 1'b1) begin
            w = pack(wideSel, chan);
            // output stage, fifo and hold register
            if (q.size() == 32'h12) begin
                q[17] = w;
                ovExp++;
            end else begin
                q.push_back(w);
            end
            if (activeExp > 0) check(sinceDone == activeExp, "data period");
            activeExp = pendingExp;
            sinceDone = 1;
            wideSel = 1'($urandom);
            for (int k = 0; k < 4; k++) chan[k] = 24'($urandom);
        end else begin
            sinceDone++;
        end
    end
    initial begin
        #(95000 * 25);
        check(1'b0, "watchdog expired");
        tallyAndFinish();
    end
    initial begin
        void'($urandom(66873));
        rst_b = 1'b0;
        rateWrite = 1'b0;
        rateWriteData = 16'h0000;
        wideSel = 1'b1;
        mode = 2'h1;
        for (i = 0; i < 4; i++) chan[i] = 24'($urandom);
        repeat (8) @(negedge ref_clk);
        rst_b = 1'b1;
        check(rateReadData === 16'h0000 && resultValid === 1'b0, "reset state");
        @(negedge ref_clk);
        wr(16'h5fff);
        for (i = 0; i < 4; i++) wr(16'($urandom));
        wr(sched[0]);
        rateWrite = 1'b0;
        sched[2] = {5'h00, 11'($urandom_range(15))};
        for (i = 1; i < 8; i++) begin
            waitDone();
            @(negedge ref_clk);
            wr(sched[i]);
            rateWrite = 1'b0;
        end
        waitDone();
        waitDone();
        mode <= 2'h2;
        repeat (21) waitDone();
        mode <= 2'h0;
        repeat (40) @(negedge ref_clk);
        check(q.size() == 0, "words left unread");
        check(ovSeen == ovExp && ovExp > 0, "overwrite count");
        tallyAndFinish();
    end
endmodule
